// ===== rxfsp_regs.sv
// apb register bank for rx forwarding, flow threshold and suspend pins
//
// Behaviour
// - without low latency, wait full packet or timeout
// - under class driver, packet limit is sixty-three
// - low latency forwards available data at once
// - class driver below 40960 baud sets latency
// - flow control asserts at fifo threshold count
// - flow threshold resets to 450
// - write-only driver select picks class or custom
// - override clear keeps pin outputs during suspend
// - override set drives configured suspend levels
// - one level bit per pin, reset zero
// - config bit per pin: active or open-drain
`timescale 1ns/1ps
`default_nettype none
module rxfsp_regs (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   // apb slave
   input  wire logic [11:0]                    paddr,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [31:0]                    pwdata,
   output logic [31:0]                         prdata,
   output logic                                pready,
   output logic                                pslverr,
   // receive path
   input  wire logic                           bulk_in_req,
   input  wire logic                           rx_byte_push,
   input  wire logic [rxfsp_pkg::THRESH_W-1:0] rx_fifo_count,
   input  wire logic [rxfsp_pkg::BAUD_W-1:0]   baud_rate,
   input  wire logic [3:0]                     char_bits,
   // forwarding and flow control
   output logic                                forward_go,
   output logic [rxfsp_pkg::LEN_W-1:0]         forward_len,
   output logic                                flow_ctrl_assert,
   output logic                                latency_active,
   output logic                                custom_driver,
   // suspend pin control
   input  wire logic                           usb_suspend,
   input  wire logic [rxfsp_pkg::PIN_W-1:0]    gpio_out,
   input  wire logic [rxfsp_pkg::PIN_W-1:0]    gpio_oe_n,
   output logic [rxfsp_pkg::PIN_W-1:0]         pin_out,
   output logic [rxfsp_pkg::PIN_W-1:0]         pin_oe_n
);
   import rxfsp_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic                rx_latency;
   logic [THRESH_W-1:0] rx_threshold;
   logic                drv_custom;
   logic [15:0]         susp_level;
   logic [15:0]         susp_config;
   logic                wr_en;
   logic                rd_setup;
   logic                mapped;
   logic [31:0]         next_prdata;
   logic                baud_low;
   logic [LEN_W-1:0]    pkt_size;
   logic                pkt_full;
   logic                timer_expired;
   logic                timer_run;
   logic                timer_restart;
   logic [PIN_W-1:0]    ovr_out;
   logic [PIN_W-1:0]    ovr_oe_n;
   logic [PIN_W-1:0]    pin_mask_w;
   logic                override_en;

   rxfsp_fwd_state_type state;
   rxfsp_fwd_state_type next_state;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = hit(paddr, ADDR_LATENCY)   ||
                     hit(paddr, ADDR_THRESHOLD) ||
                     hit(paddr, ADDR_DRIVER)    ||
                     hit(paddr, ADDR_SUSP_LVL)  ||
                     hit(paddr, ADDR_SUSP_CFG);

   // zero wait states: every access completes in its access phase
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ----------------------------------------------------------------
   // latency control
   // ----------------------------------------------------------------
   assign baud_low = baud_rate < LOW_BAUD;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_latency <= LAT_RST;
      end else if (!drv_custom && baud_low) begin
         // auto set wins over a software clear in the same cycle
         rx_latency <= 1'b1;
      end else if (wr_en && hit(paddr, ADDR_LATENCY)) begin
         rx_latency <= pwdata[LAT_EN_POS];
      end
   end

   // ----------------------------------------------------------------
   // flow threshold
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_threshold <= THRESH_RST;
      end else if (wr_en && hit(paddr, ADDR_THRESHOLD)) begin
         rx_threshold <= pwdata[THRESH_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flow_ctrl_assert <= 1'b0;
      end else begin
         flow_ctrl_assert <= rx_fifo_count >= rx_threshold;
      end
   end

   // ----------------------------------------------------------------
   // driver select
   // ----------------------------------------------------------------
   // a custom host driver must set this before class requests
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drv_custom <= DRV_RST;
      end else if (wr_en && hit(paddr, ADDR_DRIVER)) begin
         drv_custom <= pwdata[DRV_SEL_POS];
      end
   end

   // ----------------------------------------------------------------
   // suspend level and config
   // ----------------------------------------------------------------
   // reserved positions are masked off so they always read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         susp_level <= LVL_RST;
      end else if (wr_en && hit(paddr, ADDR_SUSP_LVL)) begin
         susp_level <= pwdata[15:0] & PIN_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         susp_config <= CFG_RST;
      end else if (wr_en && hit(paddr, ADDR_SUSP_CFG)) begin
         susp_config <= pwdata[15:0] & (PIN_MASK | 16'h8000);
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      next_prdata = 32'h00000000;
      if (hit(paddr, ADDR_LATENCY)) begin
         next_prdata[LAT_EN_POS] = rx_latency;
      end else if (hit(paddr, ADDR_THRESHOLD)) begin
         next_prdata[THRESH_W-1:0] = rx_threshold;
      end else if (hit(paddr, ADDR_SUSP_LVL)) begin
         next_prdata[15:0] = susp_level;
      end else if (hit(paddr, ADDR_SUSP_CFG)) begin
         next_prdata[15:0] = susp_config;
      end
   end

   // write-only driver select and unmapped addresses read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= next_prdata;
      end
   end

   // ----------------------------------------------------------------
   // bulk-in forwarding
   // ----------------------------------------------------------------
   assign latency_active = rx_latency;
   assign custom_driver  = drv_custom;
   assign pkt_size       = drv_custom ? MAX_PKT : CDC_PKT;
   assign pkt_full       = rx_fifo_count >= {3'b000, pkt_size};

   // the timeout only counts while bytes sit waiting
   assign timer_run     = (state == FW_WAIT) && (rx_fifo_count != 10'h000);
   assign timer_restart = rx_byte_push || (state != FW_WAIT);

   rxfsp_char_timer u_char_timer (
      .clk       (clk),
      .rst_n     (rst_n),
      .restart   (timer_restart),
      .run       (timer_run),
      .baud_rate (baud_rate),
      .char_bits (char_bits),
      .expired   (timer_expired)
   );

   always_comb begin
      next_state = state;
      case (state)
         FW_IDLE: begin
            if (bulk_in_req) begin
               if (rx_latency) begin
                  next_state = FW_SEND;
               end else begin
                  next_state = FW_WAIT;
               end
            end
         end
         FW_WAIT: begin
            if (rx_latency || pkt_full || timer_expired) begin
               next_state = FW_SEND;
            end
         end
         FW_SEND: begin
            next_state = FW_IDLE;
         end
         default: begin
            next_state = FW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= FW_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // release is capped at one packet; the rest waits for the next request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         forward_go  <= 1'b0;
         forward_len <= 7'h00;
      end else begin
         forward_go <= (state == FW_SEND);
         if (state == FW_SEND) begin
            if (pkt_full) begin
               forward_len <= pkt_size;
            end else begin
               forward_len <= rx_fifo_count[LEN_W-1:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // suspend pin override
   // ----------------------------------------------------------------
   assign override_en = susp_config[OVERRIDE_POS];
   assign pin_mask_w  = PIN_MASK[PIN_W-1:0];

   // open drain pulls low for a zero and floats for a one
   generate
      for (genvar i = 0; i < PIN_W; i++) begin : g_pin
         always_comb begin
            if (susp_config[i]) begin
               ovr_out[i]  = 1'b0;
               ovr_oe_n[i] = susp_level[i];
            end else begin
               ovr_out[i]  = susp_level[i];
               ovr_oe_n[i] = 1'b0;
            end
         end
      end
   endgenerate

   // outputs stay registered so a suspended pin keeps its value unless the override drives it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out  <= '0;
         pin_oe_n <= '1;
      end else if (!usb_suspend) begin
         pin_out  <= gpio_out;
         pin_oe_n <= gpio_oe_n;
      end else if (override_en) begin
         pin_out  <= (pin_out & ~pin_mask_w) | (ovr_out & pin_mask_w);
         pin_oe_n <= (pin_oe_n & ~pin_mask_w) | (ovr_oe_n & pin_mask_w);
      end else begin
         pin_out  <= pin_out;
         pin_oe_n <= pin_oe_n;
      end
   end

endmodule
`default_nettype wire

// ===== rxfsp_pkg.sv
// constants and types for the rx forwarding and suspend pin register bank
package rxfsp_pkg;

   // ----------------------------------------------------------------
   // register indices and apb byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_LATENCY   = 12'h046;
   localparam logic [11:0] IDX_THRESHOLD = 12'h047;
   localparam logic [11:0] IDX_DRIVER    = 12'h060;
   localparam logic [11:0] IDX_SUSP_LVL  = 12'h06a;
   localparam logic [11:0] IDX_SUSP_CFG  = 12'h06b;
   localparam logic [11:0] ADDR_LATENCY   = IDX_LATENCY << 2;
   localparam logic [11:0] ADDR_THRESHOLD = IDX_THRESHOLD << 2;
   localparam logic [11:0] ADDR_DRIVER    = IDX_DRIVER << 2;
   localparam logic [11:0] ADDR_SUSP_LVL  = IDX_SUSP_LVL << 2;
   localparam logic [11:0] ADDR_SUSP_CFG  = IDX_SUSP_CFG << 2;

   // ----------------------------------------------------------------
   // field positions and widths
   // ----------------------------------------------------------------
   localparam int          LAT_EN_POS   = 0;
   localparam int          DRV_SEL_POS  = 0;
   localparam int          OVERRIDE_POS = 15;
   localparam int          THRESH_W     = 10;
   localparam int          PIN_W        = 14;
   localparam int          BAUD_W       = 24;
   localparam int          LEN_W        = 7;
   localparam int          PIN_DSR      = 13;
   localparam int          PIN_DTR      = 12;
   localparam int          PIN_RI       = 11;
   localparam int          PIN_CD       = 10;
   localparam int          PIN_RECEIVE  = 7;
   localparam int          PIN_TRANSMIT = 6;
   localparam int          PIN_XCVR_DIR = 3;
   localparam int          PIN_CTS      = 2;
   localparam int          PIN_RTS      = 1;
   localparam int          PIN_CLK_OUT  = 0;
   localparam logic [15:0] PIN_MASK     = 16'h3ccf;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic                LAT_RST    = 1'b0;
   localparam logic [THRESH_W-1:0] THRESH_RST = 10'h1c2;
   localparam logic                DRV_RST    = 1'b0;
   localparam logic [15:0]         LVL_RST    = 16'h0000;
   localparam logic [15:0]         CFG_RST    = 16'h0000;

   // ----------------------------------------------------------------
   // timing and packet figures
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam logic [24:0] CLK_HZ_W      = 25'(CLK_HZ);
   localparam logic [LEN_W-1:0]  MAX_PKT  = 7'h40;
   localparam logic [LEN_W-1:0]  CDC_PKT  = 7'h3f;
   localparam logic [BAUD_W-1:0] LOW_BAUD = 24'h00a000;
   localparam int          CHAR_TIMES    = 3;

   typedef enum logic [2:0] {
      FW_IDLE = 3'b001,
      FW_WAIT = 3'b010,
      FW_SEND = 3'b100
   } rxfsp_fwd_state_type;

endpackage

// ===== rxfsp_char_timer.sv
// character-time timeout counter for held receive data
`timescale 1ns/1ps
`default_nettype none
module rxfsp_char_timer (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // control
   input  wire logic                         restart,
   input  wire logic                         run,
   // frame timing
   input  wire logic [rxfsp_pkg::BAUD_W-1:0] baud_rate,
   input  wire logic [3:0]                   char_bits,
   // status
   output logic                              expired
);
   import rxfsp_pkg::*;

   logic [24:0] acc;
   logic [24:0] sum;
   logic [5:0]  bit_cnt;
   logic [5:0]  limit;

   // ----------------------------------------------------------------
   // fractional bit-time tick
   // ----------------------------------------------------------------
   // baud above the core clock saturates at one bit per cycle
   assign sum   = acc + {1'b0, baud_rate};
   assign limit = 6'(CHAR_TIMES) * {2'b00, char_bits};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 25'h0000000;
      end else if (restart || !run) begin
         acc <= 25'h0000000;
      end else if (sum >= CLK_HZ_W) begin
         acc <= sum - CLK_HZ_W;
      end else begin
         acc <= sum;
      end
   end

   // each new byte starts the wait over
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= 6'h00;
      end else if (restart) begin
         bit_cnt <= 6'h00;
      end else if (run && sum >= CLK_HZ_W && bit_cnt < limit) begin
         bit_cnt <= bit_cnt + 6'h01;
      end
   end

   assign expired = run && (bit_cnt >= limit);

endmodule
`default_nettype wire

// ===== rxfsp_regs_monitor.sv
// assertion checker for the rx forwarding and suspend pin bank
`timescale 1ns/1ps
`default_nettype none
module rxfsp_regs_monitor
   import rxfsp_pkg::*;
(
   // clock, reset and apb
   input wire logic        clk, rst_n, psel, penable, pwrite, pready,
   input wire logic        pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // receive path and forwarding
   input wire logic        bulk_in_req, rx_byte_push, forward_go,
   input wire logic        flow_ctrl_assert, latency_active, custom_driver,
   input wire logic [9:0]  rx_fifo_count,
   input wire logic [23:0] baud_rate,
   input wire logic [3:0]  char_bits,
   input wire logic [6:0]  forward_len,
   // suspend pins
   input wire logic        usb_suspend,
   input wire logic [13:0] gpio_out, gpio_oe_n, pin_out, pin_oe_n
);
   logic [9:0]  thr;
   logic [13:0] lvl, cfg, drv_out, drv_oe;
   logic        ovr, busy, wr, hit;
   assign wr  = psel && penable && pwrite && pready;
   assign hit = paddr inside {ADDR_LATENCY, ADDR_THRESHOLD, ADDR_DRIVER,
                              ADDR_SUSP_LVL, ADDR_SUSP_CFG};
   assign drv_out = lvl & ~cfg & PIN_MASK[13:0];
   assign drv_oe  = lvl & cfg & PIN_MASK[13:0];
   // ----------------------------------------------------------------
   // shadow copies of the registers the pins and flow depend on
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thr <= THRESH_RST;
         lvl <= 14'h0000;
         cfg <= 14'h0000;
         ovr <= 1'b0;
      end else if (wr) begin
         if (paddr == ADDR_THRESHOLD) thr <= pwdata[9:0];
         if (paddr == ADDR_SUSP_LVL) lvl <= pwdata[13:0];
         if (paddr == ADDR_SUSP_CFG) cfg <= pwdata[13:0];
         if (paddr == ADDR_SUSP_CFG) ovr <= pwdata[15];
      end
   end
   // a request is only taken while nothing is pending
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) busy <= 1'b0;
      else if (bulk_in_req && !busy) busy <= 1'b1;
      else if (forward_go) busy <= 1'b0;
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_FAST_GO: assert property (bulk_in_req && !busy && latency_active
      |-> ##2 forward_go) else $error("fast release missing");
   AST_GO_ONE: assert property (forward_go |=> !forward_go)
      else $error("release pulse too long");
   AST_GO_BUSY: assert property (forward_go |-> busy)
      else $error("release without request");
   AST_LEN_CAP: assert property (forward_go |-> forward_len <=
      (custom_driver ? MAX_PKT : CDC_PKT)) else $error("length over cap");
   AST_PKT_FULL: assert property (busy && !latency_active && !forward_go
      && rx_fifo_count >= {3'h0, custom_driver ? MAX_PKT : CDC_PKT}
      |-> ##[1:3] forward_go) else $error("full packet held");
   AST_FLOW: assert property (1'b1 |=> flow_ctrl_assert ==
      ($past(rx_fifo_count) >= $past(thr))) else $error("flow level wrong");
   AST_AUTO_LAT: assert property (!custom_driver && baud_rate < LOW_BAUD
      |=> latency_active) else $error("latency not auto set");
   AST_HOLD: assert property (usb_suspend && !ovr |=> $stable(pin_out)
      && $stable(pin_oe_n)) else $error("pins moved in suspend");
   AST_DRIVE: assert property (usb_suspend && ovr |=>
      (pin_out & PIN_MASK[13:0]) == $past(drv_out) &&
      (pin_oe_n & PIN_MASK[13:0]) == $past(drv_oe))
      else $error("suspend levels wrong");
   AST_FOLLOW: assert property (!usb_suspend |=> pin_out == $past(gpio_out)
      && pin_oe_n == $past(gpio_oe_n)) else $error("pins not following");
   AST_SLVERR: assert property (psel && penable |-> pslverr == !hit)
      else $error("slave error wrong");
   cover property (forward_go && latency_active);
   cover property (usb_suspend && ovr);
   cover property (forward_go && forward_len == MAX_PKT);
endmodule
bind rxfsp_regs rxfsp_regs_monitor mon_u (.*);
`default_nettype wire

// ===== rxfsp_host_model.sv
// host side model: bulk-in requests and receive fifo fill
`timescale 1ns/1ps
`default_nettype none
module rxfsp_host_model (
   // clock, reset and bench controls
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       want_req,
   input  wire logic       want_byte,
   // block side
   input  wire logic       forward_go,
   input  wire logic [6:0] forward_len,
   output logic            bulk_in_req,
   output logic            rx_byte_push,
   output logic [9:0]      rx_fifo_count
);
   // released bytes leave the fifo at the edge that sees the pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bulk_in_req   <= 1'b0;
         rx_byte_push  <= 1'b0;
         rx_fifo_count <= 10'h000;
      end else begin
         bulk_in_req   <= want_req;
         rx_byte_push  <= want_byte;
         rx_fifo_count <= rx_fifo_count + 10'(want_byte)
                          - (forward_go ? 10'(forward_len) : 10'h000);
      end
   end
endmodule
`default_nettype wire

// ===== rxfsp_regs_tb.sv
// self-checking bench for the rx forwarding and suspend pin bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module rxfsp_regs_tb;
   import rxfsp_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, usb_suspend = 1'b0;
   logic        want_req = 1'b0, want_byte = 1'b0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic        pready, pslverr, bulk_in_req, rx_byte_push, forward_go, er;
   logic        flow_ctrl_assert, latency_active, custom_driver;
   logic [9:0]  rx_fifo_count;
   logic [23:0] baud_rate;
   logic [3:0]  char_bits;
   logic [6:0]  forward_len;
   logic [13:0] gpio_out, gpio_oe_n, pin_out, pin_oe_n, p, q, lv, cf;
   logic [11:0] a;
   logic [11:0] adr [6] = '{ADDR_LATENCY, ADDR_THRESHOLD, ADDR_DRIVER,
                            ADDR_SUSP_LVL, ADDR_SUSP_CFG, 12'h004};
   logic [31:0] rv [6] = '{32'h0, 32'h1c2, 32'h0, 32'h0, 32'h0, 32'h0};
   int          bad_count = 0, check_count = 0, cyc = 0, fill = 0;
   int          i, w, thr, tmo;
   rxfsp_regs dut_u (.*);
   rxfsp_host_model host_u (.*);
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic        wr,
                      input logic [11:0] ad,
                      input logic [31:0] dw);
      @(posedge clk);
      psel <= 1'b1; paddr <= ad; pwrite <= wr; pwdata <= dw;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic push(input int k);
      repeat (k) begin
         @(posedge clk) want_byte <= 1'b1;
         @(posedge clk) want_byte <= 1'b0;
      end
      fill += k;
      repeat (3) @(posedge clk);
   endtask
   task automatic ask(input logic [6:0] e, output int n);
      @(posedge clk) want_req <= 1'b1;
      @(posedge clk) want_req <= 1'b0;
      n = 0;
      while (forward_go !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      `CHK("forward_len", e, forward_len)
      fill -= int'(e);
      repeat (2) @(posedge clk);
   endtask
   function automatic logic [6:0] exp_len(input int f, input logic c);
      exp_len = (f < (c ? 64 : 63)) ? 7'(f) : (c ? MAX_PKT : CDC_PKT);
   endfunction
   function automatic logic [31:0] msk(input logic [11:0] ad);
      case (ad)
         ADDR_LATENCY:   msk = 32'h1;
         ADDR_THRESHOLD: msk = 32'h3ff;
         ADDR_SUSP_LVL:  msk = {16'h0, PIN_MASK};
         ADDR_SUSP_CFG:  msk = {16'h0, PIN_MASK | 16'h8000};
         default:        msk = 32'h0;
      endcase
   endfunction
   initial begin
      paddr = '0; pwdata = '0; baud_rate = 24'h01c200; char_bits = 4'ha;
      gpio_out = '0; gpio_oe_n = '1;
      void'($urandom(32'hc5747fba));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i++) begin
         apb(1'b0, adr[i], 32'h0);
         `CHK("reset value", rv[i], rd)
         `CHK("pslverr", 1'(i == 5), er)
      end
      for (i = 0; i < 12; i++) begin
         a = adr[$urandom % 6];
         d = $urandom;
         apb(1'b1, a, d);
         apb(1'b0, a, 32'h0);
         `CHK("read back", d & msk(a), rd)
         `CHK("pslverr", 1'(a == 12'h004), er)
      end
      for (i = 0; i < 5; i++) apb(1'b1, adr[i], rv[i]);
      $display("register test done");
      apb(1'b1, ADDR_DRIVER, 32'h1);
      baud_rate <= 24'h002580;
      apb(1'b1, ADDR_LATENCY, 32'h0);
      @(negedge clk);
      `CHK("custom_driver", 1'b1, custom_driver)
      `CHK("latency", 1'b0, latency_active)
      apb(1'b1, ADDR_DRIVER, 32'h0);
      apb(1'b1, ADDR_LATENCY, 32'h0);
      apb(1'b0, ADDR_LATENCY, 32'h0);
      `CHK("auto latency", 32'h1, rd)
      baud_rate <= 24'h01c200;
      apb(1'b1, ADDR_LATENCY, 32'h0);
      @(negedge clk);
      `CHK("latency", 1'b0, latency_active)
      $display("latency test done");
      apb(1'b1, ADDR_LATENCY, 32'h1);
      for (i = 0; i < 3; i++) begin
         push(i == 0 ? 0 : $urandom % 40);
         ask(exp_len(fill, 1'b0), w);
         `CHK("fast release", 1'b1, 1'(w < 8))
      end
      apb(1'b1, ADDR_LATENCY, 32'h0);
      push(70);
      ask(exp_len(fill, 1'b0), w);
      apb(1'b1, ADDR_DRIVER, 32'h1);
      push(60);
      ask(exp_len(fill, 1'b1), w);
      tmo = 3 * 10 * CLK_HZ / 115200;
      ask(exp_len(fill, 1'b1), w);
      `CHK("timeout", 1'b1, 1'(w > tmo - 4 && w < tmo + 12))
      apb(1'b1, ADDR_DRIVER, 32'h0);
      $display("forwarding test done");
      thr = 2 + $urandom % 20;
      apb(1'b1, ADDR_THRESHOLD, 32'(thr));
      for (i = 0; i < thr + 2; i++) begin
         push(1);
         `CHK("flow", 1'(fill >= thr), flow_ctrl_assert)
      end
      apb(1'b1, ADDR_LATENCY, 32'h1);
      ask(exp_len(fill, 1'b0), w);
      $display("flow test done");
      for (i = 0; i < 4; i++) begin
         // pin inputs change only just after a rising edge
         @(posedge clk);
         gpio_out <= 14'($urandom);
         gpio_oe_n <= 14'($urandom);
         usb_suspend <= 1'b0;
         lv = 14'($urandom) & PIN_MASK[13:0];
         cf = 14'($urandom) & PIN_MASK[13:0];
         apb(1'b1, ADDR_SUSP_LVL, {18'h0, lv});
         apb(1'b1, ADDR_SUSP_CFG, {16'h0, i[0], 1'b0, cf});
         @(negedge clk);
         `CHK("pins follow", gpio_out, pin_out)
         p = pin_out;
         q = pin_oe_n;
         @(posedge clk);
         usb_suspend <= 1'b1;
         gpio_out <= ~gpio_out;
         repeat (3) @(posedge clk);
         @(negedge clk);
         if (i[0]) begin
            `CHK("suspend out", lv & ~cf, pin_out & PIN_MASK[13:0])
            `CHK("suspend oe_n", lv & cf, pin_oe_n & PIN_MASK[13:0])
         end else begin
            `CHK("hold out", p, pin_out)
            `CHK("hold oe_n", q, pin_oe_n)
         end
      end
      $display("suspend test done");
      finish_test();
   end
endmodule
`default_nettype wire
